//--- include/sac_consts.svh
// Purpose: named constants of the converter control block
// Assumes: 8-bit registers, one per aligned 32-bit APB word
// Notes: register index times four gives the byte address
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// register indices (byte address = index * 4)
`define SAC_IDX_CTRL_A 10'h00e
`define SAC_IDX_CTRL_B 10'h00f
`define SAC_IDX_RES_LOW 10'h020
`define SAC_IDX_RES_HIGH 10'h021

// reset values
`define SAC_RST_CTRL_A 8'h10
`define SAC_RST_CTRL_B 8'h10
`define SAC_RST_RESULT 10'h000

// conv_control_a fields
`define SAC_A_START 7
`define SAC_A_MODE_HI 6
`define SAC_A_MODE_LO 5
`define SAC_A_INDIS 4
`define SAC_A_CHAN_HI 3
`define SAC_A_CHAN_LO 0
`define SAC_A_CHAN_SEL_HI 2
`define SAC_A_CHAN_RSVD 3

// conv_control_b fields
`define SAC_B_LADDER 5
`define SAC_B_TIME_HI 3
`define SAC_B_TIME_LO 1
`define SAC_B_WMASK 8'h3f

// conversion lengths in high_freq_clock periods
`define SAC_T_CODE0 3'b000
`define SAC_T_CODE2 3'b010
`define SAC_T_CODE3 3'b011
`define SAC_T_CODE4 3'b100
`define SAC_T_CODE5 3'b101
`define SAC_T_CODE6 3'b110
`define SAC_T_39 11'd39
`define SAC_T_78 11'd78
`define SAC_T_156 11'd156
`define SAC_T_312 11'd312
`define SAC_T_624 11'd624
`define SAC_T_1248 11'd1248

// successive approximation timing: 10 trials of 3 cycles each
`define SAC_TRIAL_CYC 11'd30
`define SAC_SAMPLE_END 11'd31
`define SAC_SUB_DECIDE 2'd2
`define SAC_MSB_IDX 4'd9
`define SAC_MSB_CODE 10'h200

`endif

//--- include/sac_pkg.sv
// Purpose: types of the converter control block
// Assumes: constants come from sac_consts.svh
// Notes: whole block state is one packed struct
package sac_pkg;

    typedef enum logic [1:0] {
        SAC_MODE_OFF = 2'b00,
        SAC_MODE_SOFT = 2'b01,
        SAC_MODE_RSVD = 2'b10,
        SAC_MODE_REPEAT = 2'b11
    } sac_mode_type;

    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [9:0] result;
        logic done;
        logic busy;
        logic [10:0] cnt;
        logic [10:0] span;
        logic [1:0] sub;
        logic [3:0] bit_idx;
        logic [9:0] trial;
        logic [31:0] rdata;
        logic irq;
        logic cmp_meta;
        logic cmp_sync;
    } sac_state_type;

endpackage : sac_pkg

//--- hdl/sac_top.sv
// Purpose: control and result logic of a 10-bit successive approximation converter
// Assumes: pclk is the high_freq_clock; analog ladder, sample-hold, comparator are outside
// Notes: APB slave, zero wait states, registers hold 8 bits in the low lanes
//
// Overview of operation
// - Software-start mode: writing start bit begins one conversion of selected channel
// - Start bit clears itself once conversion begins, reads zero during it
// - Mode field: 00 disabled, 01 software start, 11 repeat, 10 reserved
// - Channel codes 0000..0111 select inputs zero..seven; 1000 upward reserved
// - Input disable bit: 0 enables analog inputs, 1 disables them
// - Low-power entry resets both control registers and blocks their writes
// - Time field selects 39..1248 clock periods; 001 and 111 reserved
// - Ladder bit: connected only while converting, or connected always
// - Bits 7 and 6 of control b read as undefined; this block does not store them and reads them as zero
// - Result upper eight bits in result_high, lowest two in low register 7:6
// - Storing the result sets done flag and pulses the completion irq
// - Reading result_high clears done flag; read low register first
// - Busy set at start, cleared at finish and on low-power entry
// - Bits 3 down to 0 of the low result register read as unstable; this block reads them as zero
// - Repeat mode restarts on completion; mode 00 aborts and discards result
// - A new start clears done flag but keeps the previous result
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "sac_consts.svh"

module sac_top (
    input wire logic pclk, // high_freq_clock, also the APB clock
    input wire logic presetn, // asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction, 1 = write
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data, registered
    output logic pready, // APB ready, always high
    output logic pslverr, // APB error on unmapped address
    input wire logic low_power, // core in STOP, SLOW or SLEEP, level
    input wire logic cmp_high, // comparator: input above trial level
    output logic [2:0] analog_channel, // selected analog input
    output logic channel_valid, // channel code is not reserved
    output logic analog_input_enable, // analog inputs enabled
    output logic ladder_connect, // connect resistor ladder
    output logic sample_hold, // sample phase of the conversion
    output logic [9:0] dac_code, // trial code for the ladder
    output logic conversion_busy_flag, // conversion in progress
    output logic conversion_done_flag, // result stored, not yet read
    output logic conversion_complete_irq // one-cycle completion request
);
    import sac_pkg::*;

    sac_state_type st_reg;
    sac_state_type st_next;

    logic acc_setup;
    logic acc_done;
    logic hit_a;
    logic hit_b;
    logic hit_low;
    logic hit_high;
    logic mapped;
    logic [9:0] word_idx;
    logic [7:0] wr_byte;
    logic [7:0] rd_byte;
    sac_mode_type mode_now;
    logic mode_active;
    logic start_now;
    logic [10:0] span_sel;
    logic in_trial;
    logic [9:0] decided;

    // conversion length lookup; reserved codes take the longest time so a
    // stray setting can never undercut the analog settling limit
    function automatic logic [10:0] sac_span(input logic [2:0] code);
        logic [10:0] n;
        n = `SAC_T_1248;
        case (code)
            `SAC_T_CODE0: n = `SAC_T_39;
            `SAC_T_CODE2: n = `SAC_T_78;
            `SAC_T_CODE3: n = `SAC_T_156;
            `SAC_T_CODE4: n = `SAC_T_312;
            `SAC_T_CODE5: n = `SAC_T_624;
            `SAC_T_CODE6: n = `SAC_T_1248;
            default: n = `SAC_T_1248;
        endcase
        return n;
    endfunction : sac_span

    always_comb begin
        word_idx = paddr[11:2];
        acc_setup = psel && !penable;
        acc_done = psel && penable;
        hit_a = 1'b0;
        hit_b = 1'b0;
        hit_low = 1'b0;
        hit_high = 1'b0;
        if (word_idx == `SAC_IDX_CTRL_A) begin
            hit_a = 1'b1;
        end else if (word_idx == `SAC_IDX_CTRL_B) begin
            hit_b = 1'b1;
        end else if (word_idx == `SAC_IDX_RES_LOW) begin
            hit_low = 1'b1;
        end else if (word_idx == `SAC_IDX_RES_HIGH) begin
            hit_high = 1'b1;
        end
        mapped = hit_a || hit_b || hit_low || hit_high;
    end

    always_comb begin
        st_next = st_reg;
        wr_byte = pwdata[7:0];
        rd_byte = 8'h00;
        decided = st_reg.trial;
        in_trial = 1'b0;

        // comparator crosses from the analog side: two stages before use
        st_next.cmp_meta = cmp_high;
        st_next.cmp_sync = st_reg.cmp_meta;
        st_next.irq = 1'b0;

        // register writes; low power locks both control registers
        if (acc_done && pwrite && pstrb[0] && !low_power) begin
            if (hit_a) begin
                st_next.ctrl_a = wr_byte;
            end else if (hit_b) begin
                // bits 7:6 are not stored; bits 4 and 0 kept as written
                st_next.ctrl_b = wr_byte & `SAC_B_WMASK;
            end
        end

        mode_now = sac_mode_type'(st_next.ctrl_a[`SAC_A_MODE_HI:`SAC_A_MODE_LO]);
        mode_active = (mode_now == SAC_MODE_SOFT) || (mode_now == SAC_MODE_REPEAT);
        start_now = st_next.ctrl_a[`SAC_A_START] && mode_active && !st_reg.busy;
        span_sel = sac_span(st_next.ctrl_b[`SAC_B_TIME_HI:`SAC_B_TIME_LO]);

        // result_high read clears the done flag; a completion in the same
        // cycle is handled below and wins
        if (acc_done && !pwrite && hit_high) begin
            st_next.done = 1'b0;
        end

        if (st_reg.busy) begin
            in_trial = st_reg.cnt >= (st_reg.span - `SAC_TRIAL_CYC);
            st_next.cnt = st_reg.cnt + 11'd1;
            if (st_reg.cnt == (st_reg.span - `SAC_SAMPLE_END)) begin
                // end of sampling: first trial is the most significant bit
                st_next.trial = `SAC_MSB_CODE;
                st_next.bit_idx = `SAC_MSB_IDX;
                st_next.sub = 2'd0;
            end else if (in_trial) begin
                st_next.sub = st_reg.sub + 2'd1;
                if (st_reg.sub == `SAC_SUB_DECIDE) begin
                    st_next.sub = 2'd0;
                    if (!st_reg.cmp_sync) begin
                        decided[st_reg.bit_idx] = 1'b0;
                    end
                    if (st_reg.bit_idx != 4'd0) begin
                        decided[st_reg.bit_idx - 4'd1] = 1'b1;
                        st_next.bit_idx = st_reg.bit_idx - 4'd1;
                    end
                    st_next.trial = decided;
                end
            end
            if (st_reg.cnt == (st_reg.span - 11'd1)) begin
                // final decision lands exactly on the last period
                st_next.result = decided;
                st_next.done = 1'b1;
                st_next.irq = 1'b1;
                st_next.busy = 1'b0;
                st_next.trial = 10'h000;
                if (mode_now == SAC_MODE_REPEAT) begin
                    // back-to-back conversion, new timing setting taken here
                    st_next.busy = 1'b1;
                    st_next.cnt = 11'd0;
                    st_next.span = span_sel;
                end
            end
            if (!mode_active) begin
                // disabling aborts at once; unfinished code never stored
                st_next.busy = 1'b0;
                st_next.done = st_reg.done && !(acc_done && !pwrite && hit_high);
                st_next.irq = 1'b0;
                st_next.result = st_reg.result;
                st_next.trial = 10'h000;
            end
        end else if (start_now) begin
            st_next.busy = 1'b1;
            st_next.done = 1'b0;
            st_next.cnt = 11'd0;
            st_next.span = span_sel;
            st_next.trial = 10'h000;
        end

        // start bit never survives a cycle; a request while busy is dropped
        st_next.ctrl_a[`SAC_A_START] = 1'b0;

        // read data captured in the setup phase so prdata is a flop
        if (hit_a) begin
            rd_byte = st_reg.ctrl_a;
        end else if (hit_b) begin
            rd_byte = st_reg.ctrl_b;
        end else if (hit_low) begin
            // low bits 3:0 read as zero in place of unstable data
            rd_byte = {st_reg.result[1:0], st_reg.done, st_reg.busy, 4'h0};
        end else if (hit_high) begin
            rd_byte = st_reg.result[9:2];
        end
        if (acc_setup) begin
            st_next.rdata = {24'h000000, rd_byte};
        end

        // standby: control reset, conversion abandoned, results cleared
        if (low_power) begin
            st_next.ctrl_a = `SAC_RST_CTRL_A;
            st_next.ctrl_b = `SAC_RST_CTRL_B;
            st_next.busy = 1'b0;
            st_next.done = 1'b0;
            st_next.irq = 1'b0;
            st_next.result = `SAC_RST_RESULT;
            st_next.trial = 10'h000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.ctrl_a <= `SAC_RST_CTRL_A;
            st_reg.ctrl_b <= `SAC_RST_CTRL_B;
            st_reg.result <= `SAC_RST_RESULT;
            st_reg.done <= 1'b0;
            st_reg.busy <= 1'b0;
            st_reg.cnt <= 11'd0;
            st_reg.span <= `SAC_T_39;
            st_reg.sub <= 2'd0;
            st_reg.bit_idx <= 4'd0;
            st_reg.trial <= 10'h000;
            st_reg.rdata <= 32'h00000000;
            st_reg.irq <= 1'b0;
            st_reg.cmp_meta <= 1'b0;
            st_reg.cmp_sync <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = st_reg.rdata;

    assign analog_channel = st_reg.ctrl_a[`SAC_A_CHAN_SEL_HI:`SAC_A_CHAN_LO];
    assign channel_valid = !st_reg.ctrl_a[`SAC_A_CHAN_RSVD];
    assign analog_input_enable = !st_reg.ctrl_a[`SAC_A_INDIS];
    // ladder follows busy when not held on, keeping reference current low
    assign ladder_connect = st_reg.ctrl_b[`SAC_B_LADDER] || st_reg.busy;
    assign sample_hold = st_reg.busy && (st_reg.cnt < (st_reg.span - `SAC_TRIAL_CYC));
    assign dac_code = st_reg.trial;
    assign conversion_busy_flag = st_reg.busy;
    assign conversion_done_flag = st_reg.done;
    assign conversion_complete_irq = st_reg.irq;

endmodule : sac_top

//--- verif/sac_cmp_model.sv
// Purpose: comparator and sample-hold stand-in for the converter
// Assumes: input n sits at level n*128+39
// Notes: level is frozen outside sampling, like a real hold capacitor
`timescale 1ns/1ps
module sac_cmp_model (
    input wire logic pclk, // converter clock
    input wire logic presetn, // reset, active low
    input wire logic [2:0] analog_channel, // selected input
    input wire logic sample_hold, // sampling phase
    input wire logic [9:0] dac_code, // trial level
    output logic cmp_high // input above trial level
);
    logic [9:0] held_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_reg <= 10'h000;
        end else if (sample_hold) begin
            held_reg <= {analog_channel, 7'h27};
        end
    end
    assign cmp_high = held_reg > dac_code;
endmodule : sac_cmp_model

//--- verif/sac_sva.sv
// Purpose: port checks of the converter control block
// Assumes: byte addresses 0x38 0x3c 0x80 0x84, byte strobes set while converting
// Notes: a start lands at its own write edge, so the cycle count restarts there
`timescale 1ns/1ps
module sac_sva (
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic psel, // select
    input wire logic penable, // access
    input wire logic pwrite, // direction
    input wire logic [11:0] paddr, // address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pslverr, // error
    input wire logic low_power, // standby
    input wire logic conversion_busy_flag, // busy
    input wire logic conversion_done_flag, // done
    input wire logic conversion_complete_irq // completion
);
    logic acc;
    logic rd_acc;
    logic wr_a;
    logic start_wr;
    logic [2:0] tcode_reg;
    logic [11:0] cyc_reg;
    logic [11:0] span;
    assign acc = psel && penable;
    assign rd_acc = acc && !pwrite;
    assign wr_a = acc && pwrite && paddr == 12'h038 && !low_power;
    assign start_wr = wr_a && pwdata[7] && pwdata[5] && !conversion_busy_flag;
    always_comb begin
        case (tcode_reg)
            3'b000: span = 12'd39;
            3'b010: span = 12'd78;
            3'b011: span = 12'd156;
            3'b100: span = 12'd312;
            3'b101: span = 12'd624;
            default: span = 12'd1248;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcode_reg <= 3'b000;
            cyc_reg <= 12'h000;
        end else begin
            if (low_power) tcode_reg <= 3'b000;
            else if (acc && pwrite && paddr == 12'h03c) tcode_reg <= pwdata[3:1];
            if (start_wr) cyc_reg <= 12'h000;
            else if (conversion_complete_irq) cyc_reg <= 12'h001;
            else cyc_reg <= cyc_reg + 12'h001;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_start;
        start_wr;
    endsequence
    sequence s_abort;
        wr_a && pwdata[6:5] == 2'b00 && conversion_busy_flag;
    endsequence
    a_start_busy: assert property (
        s_start |-> ##1 conversion_busy_flag && !conversion_done_flag)
        else $error("busy not raised after start");
    a_start_clear: assert property (
        rd_acc && paddr == 12'h038 && $past(conversion_busy_flag) |-> !prdata[7])
        else $error("start bit seen during conversion");
    a_irq_done: assert property (conversion_complete_irq |-> conversion_done_flag)
        else $error("irq without done flag");
    a_irq_pulse: assert property (conversion_complete_irq |=> !conversion_complete_irq)
        else $error("irq longer than one cycle");
    a_conv_span: assert property (conversion_complete_irq |-> cyc_reg == span)
        else $error("conversion length wrong");
    a_read_clears: assert property (
        rd_acc && paddr == 12'h084 |=> !conversion_done_flag || conversion_complete_irq)
        else $error("done flag kept after high read");
    a_abort_stop: assert property (
        s_abort |=> !conversion_complete_irq ##1 !conversion_busy_flag && !conversion_complete_irq)
        else $error("abort did not stop conversion");
    a_low_power: assert property (
        low_power |=> !conversion_busy_flag && !conversion_done_flag)
        else $error("standby left flags set");
    a_ctrl_b_read: assert property (rd_acc && paddr == 12'h03c |-> prdata[31:6] == 26'h0)
        else $error("control b upper bits not zero");
    a_bad_addr: assert property (
        rd_acc && !(paddr inside {12'h038, 12'h03c, 12'h080, 12'h084}) |-> pslverr)
        else $error("unmapped read not flagged");
endmodule : sac_sva

bind sac_top sac_sva u_sac_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .low_power(low_power), .conversion_busy_flag(conversion_busy_flag),
    .conversion_done_flag(conversion_done_flag),
    .conversion_complete_irq(conversion_complete_irq));

//--- verif/sac_top_test.sv
// Purpose: register-level bench of the converter control block
// Assumes: comparator model puts input n at n*128+39, so result is one less
// Notes: exact start and abort timing is left to the checker
`timescale 1ns/1ps
module sac_top_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, low_power = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, cmp_high, sh, busy, done, irq, err, lad, ain_en, chv;
    logic [3:0] strb = 4'hf;
    logic [2:0] chan;
    logic [9:0] dac, exp;
    logic [7:0] rd;
    int error_cnt = 0, checks_done = 0;
    sac_top u_sac_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .low_power(low_power), .cmp_high(cmp_high),
        .analog_channel(chan), .channel_valid(chv), .analog_input_enable(ain_en),
        .ladder_connect(lad),
        .sample_hold(sh), .dac_code(dac), .conversion_busy_flag(busy),
        .conversion_done_flag(done), .conversion_complete_irq(irq));
    sac_cmp_model u_sac_cmp_model (.pclk(pclk), .presetn(presetn), .analog_channel(chan),
        .sample_hold(sh), .dac_code(dac), .cmp_high(cmp_high));
    initial forever #20 pclk = ~pclk;
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            end_of_test();
        end
        @(posedge pclk);
    endtask : apb
    // polls the flag register; one poll costs three cycles
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            apb(0, 12'h080, 0);
            n++;
        end while (rd[5] !== 1'b1 && n < 1000);
        if (n >= 1000) begin
            error_cnt++;
            end_of_test();
        end
    endtask : wait_done
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 12'h038, 0);
        chk("ctrl_a", 8'h10, rd);
        apb(0, 12'h084, 0);
        chk("result_high", 8'h00, rd);
        apb(0, 12'h040, 0);
        chk("slverr", 1, err);
        for (int i = 0; i < 8; i++) begin
            exp = {i[2:0], 7'h26};
            apb(1, 12'h03c, {4'h1, i[2:0], 1'b0});
            apb(1, 12'h038, {4'ha, 1'b0, i[2:0]});
            apb(0, 12'h038, 0);
            chk("ctrl_a run", {4'h2, 1'b0, i[2:0]}, rd);
            chk("input enable", 1, ain_en);
            chk("ladder run", 1, lad);
            apb(0, 12'h080, 0);
            chk("flags run", {i == 0 ? 2'b00 : 2'b10, 6'h10}, rd);
            wait_done();
            chk("flags end", {exp[1:0], 6'h20}, rd);
            chk("ladder idle", 0, lad);
            if (i != 3) begin
                apb(0, 12'h084, 0);
                chk("result_high", exp[9:2], rd);
                apb(0, 12'h080, 0);
                chk("done clear", {exp[1:0], 6'h00}, rd);
            end
        end
        apb(1, 12'h038, 8'hc8);
        apb(0, 12'h038, 0);
        chk("reserved mode", 8'h48, rd);
        chk("reserved busy", 0, busy);
        chk("channel valid", 0, chv);
        apb(1, 12'h03c, 8'h10);
        apb(1, 12'h038, 8'he5);
        wait_done();
        apb(0, 12'h084, 0);
        wait_done();
        chk("repeat", {2'b10, 6'h30}, rd);
        apb(1, 12'h038, 8'h05);
        apb(0, 12'h080, 0);
        chk("abort", {2'b10, 6'h20}, rd);
        apb(1, 12'h038, 8'ha1);
        low_power <= 1'b1;
        @(posedge pclk);
        apb(1, 12'h038, 8'h03);
        apb(0, 12'h038, 0);
        chk("standby ctrl_a", 8'h10, rd);
        apb(0, 12'h080, 0);
        chk("standby flags", 8'h00, rd);
        chk("standby enable", 0, ain_en);
        chk("standby ladder", 0, lad);
        chk("standby channel", 1, chv);
        low_power <= 1'b0;
        apb(1, 12'h03c, 8'hfe);
        apb(0, 12'h03c, 0);
        chk("ctrl_b", 8'h3e, rd);
        chk("ladder held", 1, lad);
        // a write without the low byte strobe must leave the register alone
        strb <= 4'h0;
        apb(1, 12'h03c, 8'h10);
        apb(0, 12'h03c, 0);
        chk("strobe off", 8'h3e, rd);
        end_of_test();
    end
endmodule : sac_top_test
